// >>> watchdog_interval_timer_defines.vh
// Purpose: Shared constants of the watchdog / interval timer.
// Assumes: Byte-wide registers behind a plain strobe port.
// Notes: Indices are the register positions on the plain port.
`ifndef WATCHDOG_INTERVAL_TIMER_DEFINES_VH
`define WATCHDOG_INTERVAL_TIMER_DEFINES_VH

// Read indices
`define IDX_RD_CTRL 2'h0
`define IDX_RD_COUNT 2'h1
`define IDX_RD_RSTCTL 2'h3
// Write indices (control and counter share one)
`define IDX_WR_CTRL_COUNT 2'h0
`define IDX_WR_RSTCTL 2'h2

// Write keys in the upper byte of the word
`define KEY_COUNT 8'h5a
`define KEY_CTRL 8'ha5
`define KEY_RST_FIELDS 8'h5a
`define KEY_WDFLAG_CLEAR 8'ha5

// Control/status field positions
`define CTRL_OVF_BIT 7
`define CTRL_MODE_BIT 6
`define CTRL_EN_BIT 5
`define CTRL_DIV_HI 2
`define CTRL_DIV_LO 0
`define CTRL_RESET 8'h18
`define CTRL_FIXED_ONES 8'h18

// Reset control/status field positions
`define RST_WDFLAG_BIT 7
`define RST_EN_BIT 6
`define RST_TYPE_BIT 5
`define RST_RESET 8'h1f
`define RST_FIXED_ONES 8'h1f

// Counter reset value
`define COUNT_RESET 8'h00
`define COUNT_TOP 8'hff

// Pulse lengths in system clock cycles
`define OVF_PULSE_CYCLES 10'd128
`define INT_RESET_CYCLES 10'd512

`endif

// >>> watchdog_interval_timer.v
// Purpose: 8-bit watchdog / interval timer with key-protected writes.
// Assumes: One clock ref_clk, async active-low reset from the external pin.
// Notes: Read data appear the cycle after the read strobe, unmapped reads give 0.
//
// Behaviour
// - Watchdog mode overflow drives overflow_output_n low for 128 cycles.
// - With reset enable, watchdog overflow also raises internal reset for 512 cycles.
// - Reset type select picks power-on or manual internal reset.
// - External reset pin wins over watchdog reset and clears watchdog flag.
// - Watchdog reset leaves pin-function and port registers untouched.
// - Interval mode overflow issues an interval interrupt request.
// - Enable must be cleared before standby; standby is refused otherwise.
// - NMI in standby restarts counting; wrap to zero ends standby.
// - Interval overflow sets interval flag together with the interrupt.
// - Watchdog overflow sets watchdog flag with the overflow output.
// - Counter write beats a simultaneous increment.
// - Without reset enable, overflow only resets counter and control register.
// - Divider select codes give clock/2,64,128,256,512,1024,4096,8192.
// - Word writes carry key 0x5A for counter, 0xA5 for control.
// - Enable at zero holds counter at zero except during NMI wake-up, when it counts; enable at one counts.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "watchdog_interval_timer_defines.vh"

module watchdog_interval_timer #(
  parameter ADDR_W = 2
) (
  input wire ref_clk,
  input wire rstn,
  input wire [ADDR_W-1:0] regAddr,
  input wire [15:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  input wire standbyReq,
  input wire nmiPin,
  output wire standbyActive,
  output wire standbyRefused,
  output wire intervalInterrupt,
  output wire overflow_output_n,
  output wire internalReset,
  output wire internalResetPowerOn,
  output wire internalResetManual,
  output wire portInitReq
);

  localparam ST_RUN = 2'd0;
  localparam ST_STANDBY = 2'd1;
  localparam ST_WAKE = 2'd2;

  reg [7:0] countReg_ff;
  reg [7:0] nxt_countReg;
  reg ovf_ff;
  reg nxt_ovf;
  reg mode_ff;
  reg nxt_mode;
  reg enBit_ff;
  reg nxt_enBit;
  reg [2:0] divSel_ff;
  reg [2:0] nxt_divSel;
  reg wdFlag_ff;
  reg nxt_wdFlag;
  reg rstEn_ff;
  reg nxt_rstEn;
  reg rstType_ff;
  reg nxt_rstType;
  reg ovfArmed_ff;
  reg nxt_ovfArmed;
  reg wdFlagArmed_ff;
  reg nxt_wdFlagArmed;
  reg [12:0] presc_ff;
  reg [9:0] ovfPulse_ff;
  reg [9:0] nxt_ovfPulse;
  reg [9:0] rstPulse_ff;
  reg [9:0] nxt_rstPulse;
  reg rstTypePor_ff;
  reg nxt_rstTypePor;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg refused_ff;
  reg nmiMeta_ff;
  reg nmiSync_ff;
  reg nmiLast_ff;
  reg portInit_ff;

  // Mask of low prescaler bits whose all-ones state marks one tick
  function [12:0] divMask;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: divMask = 13'h0001;
        3'h1: divMask = 13'h003f;
        3'h2: divMask = 13'h007f;
        3'h3: divMask = 13'h00ff;
        3'h4: divMask = 13'h01ff;
        3'h5: divMask = 13'h03ff;
        3'h6: divMask = 13'h0fff;
        default: divMask = 13'h1fff;
      endcase
    end
  endfunction

  wire [12:0] selMask = divMask(divSel_ff);
  wire tick = ((presc_ff & selMask) == selMask);
  wire counting = enBit_ff | (state_ff == ST_WAKE);
  wire wrap = counting && tick && (countReg_ff == `COUNT_TOP);
  wire runWrap = wrap && (state_ff == ST_RUN) && enBit_ff;
  wire wdOverflow = runWrap && mode_ff;
  wire itOverflow = runWrap && !mode_ff;
  wire nmiRise = nmiSync_ff && !nmiLast_ff;

  wire wrCtrlCount = regWr && (regAddr == `IDX_WR_CTRL_COUNT);
  wire wrCount = wrCtrlCount && (regWdata[15:8] == `KEY_COUNT);
  wire wrCtrl = wrCtrlCount && (regWdata[15:8] == `KEY_CTRL);
  wire wrRst = regWr && (regAddr == `IDX_WR_RSTCTL);
  wire wrRstFields = wrRst && (regWdata[15:8] == `KEY_RST_FIELDS);
  wire wrWdFlagClr = wrRst && (regWdata[15:8] == `KEY_WDFLAG_CLEAR) && (regWdata[7:0] == 8'h00);
  wire rdCtrl = regRd && (regAddr == `IDX_RD_CTRL);
  wire rdRst = regRd && (regAddr == `IDX_RD_RSTCTL);

  wire [7:0] ctrlView = {ovf_ff, mode_ff, enBit_ff, 2'b00, divSel_ff} | `CTRL_FIXED_ONES;
  wire [7:0] rstView = {wdFlag_ff, rstEn_ff, rstType_ff, 5'h00} | `RST_FIXED_ONES;

  // Prescaler free-runs; it is held at zero in standby until the NMI wake-up so wake timing is clean
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      presc_ff <= 13'h0000;
    end else if (state_ff == ST_STANDBY) begin
      presc_ff <= 13'h0000;
    end else begin
      presc_ff <= presc_ff + 13'h0001;
    end
  end

  // NMI pin synchroniser; only the second stage feeds the edge detector
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nmiMeta_ff <= 1'b0;
      nmiSync_ff <= 1'b0;
      nmiLast_ff <= 1'b0;
    end else begin
      nmiMeta_ff <= nmiPin;
      nmiSync_ff <= nmiMeta_ff;
      nmiLast_ff <= nmiSync_ff;
    end
  end

  // Counter and control/status next values
  always @* begin
    nxt_countReg = countReg_ff;
    nxt_ovf = ovf_ff;
    nxt_mode = mode_ff;
    nxt_enBit = enBit_ff;
    nxt_divSel = divSel_ff;
    nxt_ovfArmed = ovfArmed_ff;
    if (counting && tick) begin
      nxt_countReg = countReg_ff + 8'h01;
    end
    if (wrCount) begin
      nxt_countReg = regWdata[7:0];
    end
    if (rdCtrl && ovf_ff) begin
      nxt_ovfArmed = 1'b1;
    end
    if (wrCtrl) begin
      nxt_mode = regWdata[`CTRL_MODE_BIT];
      nxt_enBit = regWdata[`CTRL_EN_BIT];
      nxt_divSel = regWdata[`CTRL_DIV_HI:`CTRL_DIV_LO];
      if (ovfArmed_ff && !regWdata[`CTRL_OVF_BIT]) begin
        nxt_ovf = 1'b0;
        nxt_ovfArmed = 1'b0;
      end
    end
    if (!nxt_enBit && (state_ff == ST_RUN)) begin
      nxt_countReg = `COUNT_RESET;
    end
    if (itOverflow) begin
      nxt_ovf = 1'b1;
    end
    if (wdOverflow) begin
      // Counter and control register return to reset in both reset-enable cases
      nxt_countReg = `COUNT_RESET;
      nxt_ovf = 1'b0;
      nxt_mode = 1'b0;
      nxt_enBit = 1'b0;
      nxt_divSel = 3'h0;
      nxt_ovfArmed = 1'b0;
    end
    if (state_ff == ST_STANDBY) begin
      nxt_countReg = `COUNT_RESET;
    end
  end

  // Reset control/status next values; overflow set wins over a clear
  always @* begin
    nxt_wdFlag = wdFlag_ff;
    nxt_rstEn = rstEn_ff;
    nxt_rstType = rstType_ff;
    nxt_wdFlagArmed = wdFlagArmed_ff;
    if (rdRst && wdFlag_ff) begin
      nxt_wdFlagArmed = 1'b1;
    end
    if (wrRstFields) begin
      nxt_rstEn = regWdata[`RST_EN_BIT];
      nxt_rstType = regWdata[`RST_TYPE_BIT];
    end
    if (wrWdFlagClr && wdFlagArmed_ff) begin
      nxt_wdFlag = 1'b0;
      nxt_wdFlagArmed = 1'b0;
    end
    if (wdOverflow) begin
      nxt_wdFlag = 1'b1;
    end
    if (state_ff == ST_STANDBY) begin
      nxt_wdFlag = 1'b0;
      nxt_rstEn = 1'b0;
      nxt_rstType = 1'b0;
      nxt_wdFlagArmed = 1'b0;
    end
  end

  // Pulse timers for the overflow pin and the internal reset
  always @* begin
    nxt_ovfPulse = ovfPulse_ff;
    nxt_rstPulse = rstPulse_ff;
    nxt_rstTypePor = rstTypePor_ff;
    if (ovfPulse_ff != 10'd0) begin
      nxt_ovfPulse = ovfPulse_ff - 10'd1;
    end
    if (rstPulse_ff != 10'd0) begin
      nxt_rstPulse = rstPulse_ff - 10'd1;
    end
    if (wdOverflow) begin
      nxt_ovfPulse = `OVF_PULSE_CYCLES;
      if (rstEn_ff) begin
        nxt_rstPulse = `INT_RESET_CYCLES;
        nxt_rstTypePor = !rstType_ff;
      end
    end
  end

  // Standby entry, refusal and NMI recovery
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (standbyReq && !enBit_ff) begin
          nxt_state = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (nmiRise) begin
          nxt_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wrap) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // External pin reset clears every flag, so it prevails over overflow
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      countReg_ff <= `COUNT_RESET;
      ovf_ff <= 1'b0;
      mode_ff <= 1'b0;
      enBit_ff <= 1'b0;
      divSel_ff <= 3'h0;
      ovfArmed_ff <= 1'b0;
      wdFlag_ff <= 1'b0;
      rstEn_ff <= 1'b0;
      rstType_ff <= 1'b0;
      wdFlagArmed_ff <= 1'b0;
      ovfPulse_ff <= 10'd0;
      rstPulse_ff <= 10'd0;
      rstTypePor_ff <= 1'b0;
      state_ff <= ST_RUN;
      refused_ff <= 1'b0;
    end else begin
      countReg_ff <= nxt_countReg;
      ovf_ff <= nxt_ovf;
      mode_ff <= nxt_mode;
      enBit_ff <= nxt_enBit;
      divSel_ff <= nxt_divSel;
      ovfArmed_ff <= nxt_ovfArmed;
      wdFlag_ff <= nxt_wdFlag;
      rstEn_ff <= nxt_rstEn;
      rstType_ff <= nxt_rstType;
      wdFlagArmed_ff <= nxt_wdFlagArmed;
      ovfPulse_ff <= nxt_ovfPulse;
      rstPulse_ff <= nxt_rstPulse;
      rstTypePor_ff <= nxt_rstTypePor;
      state_ff <= nxt_state;
      refused_ff <= standbyReq && enBit_ff && (state_ff == ST_RUN);
    end
  end

  // Port init request follows only the external pin, never the watchdog reset
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      portInit_ff <= 1'b1;
    end else begin
      portInit_ff <= 1'b0;
    end
  end

  // Read data one cycle after the strobe
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      if (regAddr == `IDX_RD_CTRL) begin
        regRdata <= ctrlView;
      end else if (regAddr == `IDX_RD_COUNT) begin
        regRdata <= countReg_ff;
      end else if (regAddr == `IDX_RD_RSTCTL) begin
        regRdata <= rstView;
      end else begin
        regRdata <= 8'h00;
      end
    end else begin
      regRdata <= 8'h00;
    end
  end

  assign intervalInterrupt = ovf_ff;
  assign overflow_output_n = (ovfPulse_ff == 10'd0);
  assign internalReset = (rstPulse_ff != 10'd0);
  assign internalResetPowerOn = internalReset && rstTypePor_ff;
  assign internalResetManual = internalReset && !rstTypePor_ff;
  assign standbyActive = (state_ff != ST_RUN);
  assign standbyRefused = refused_ff;
  assign portInitReq = portInit_ff;

endmodule

// >>> watchdog_interval_timer_checker.sv
// Purpose: Port assertions for the watchdog / interval timer.
// Assumes: One clock, rstn asynchronous and active low.
// Notes: Pulse lengths are measured by helper counters.
`timescale 1ns/1ps
module watchdog_interval_timer_checker (
  input wire ref_clk,
  input wire rstn,
  input wire standbyReq,
  input wire standbyActive,
  input wire standbyRefused,
  input wire intervalInterrupt,
  input wire overflow_output_n,
  input wire internalReset,
  input wire internalResetPowerOn,
  input wire internalResetManual,
  input wire portInitReq
);
  reg [9:0] lowCnt_ff;
  reg [9:0] rstCnt_ff;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lowCnt_ff <= 10'h000;
      rstCnt_ff <= 10'h000;
    end else begin
      lowCnt_ff <= overflow_output_n ? 10'h000 : lowCnt_ff + 10'h001;
      rstCnt_ff <= internalReset ? rstCnt_ff + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence wdOvf;
    $fell(overflow_output_n);
  endsequence
  sequence itvRise;
    $rose(intervalInterrupt);
  endsequence
  a_ovf_len_exact: assert property ($rose(overflow_output_n) |-> lowCnt_ff == 10'd128)
    else $error("overflow output low length wrong");
  a_ovf_len_max: assert property (lowCnt_ff <= 10'd128)
    else $error("overflow output low too long");
  a_rst_len_exact: assert property ($fell(internalReset) |-> rstCnt_ff == 10'd512)
    else $error("internal reset length wrong");
  a_rst_with_ovf: assert property ($rose(internalReset) |-> wdOvf)
    else $error("internal reset without overflow output");
  a_rst_type_one: assert property ((internalResetPowerOn | internalResetManual) == internalReset
    && !(internalResetPowerOn && internalResetManual))
    else $error("reset type outputs inconsistent");
  a_port_keep: assert property (internalReset |-> !portInitReq)
    else $error("port init during watchdog reset");
  a_modes_apart: assert property (itvRise |-> overflow_output_n)
    else $error("interval overflow drove overflow output");
  a_refuse_pulse: assert property (standbyRefused |-> $past(standbyReq) && !standbyActive
    ##1 !standbyRefused)
    else $error("standby refusal wrong");
  a_standby_entry: assert property ($rose(standbyActive) |-> $past(standbyReq))
    else $error("standby entered without request");
endmodule
bind watchdog_interval_timer watchdog_interval_timer_checker chk (.ref_clk, .rstn, .standbyReq,
  .standbyActive, .standbyRefused, .intervalInterrupt, .overflow_output_n, .internalReset,
  .internalResetPowerOn, .internalResetManual, .portInitReq);

// >>> sys_reset_circuit.sv
// Purpose: External system reset circuit driven by the overflow output.
// Assumes: Overflow output active low, sampled on the system clock.
// Notes: Its request never reaches rstn, so the block can still initialise.
`timescale 1ns/1ps
module sys_reset_circuit (
  input wire ref_clk,
  input wire overflow_output_n,
  output reg [7:0] resetCount
);
  reg prevLevel_ff = 1'b1;
  initial resetCount = 8'h00;
  always @(posedge ref_clk) begin
    prevLevel_ff <= overflow_output_n;
    if (prevLevel_ff && !overflow_output_n) resetCount <= resetCount + 8'h01;
  end
endmodule

// >>> tb_top.sv
// Purpose: Directed test of the watchdog / interval timer.
// Assumes: Register port with one-cycle strobes and read data a cycle later.
// Notes: The divider sweep dominates the run time.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_top;
  reg ref_clk = 1'b0;
  reg rstn = 1'b0;
  reg [1:0] regAddr = 2'h0;
  reg [15:0] regWdata = 16'h0000;
  reg regWr = 1'b0;
  reg regRd = 1'b0;
  reg standbyReq = 1'b0;
  reg nmiPin = 1'b0;
  wire [7:0] regRdata;
  wire [7:0] resetCount;
  wire standbyActive, standbyRefused, intervalInterrupt, overflow_output_n;
  wire internalReset, internalResetPowerOn, internalResetManual, portInitReq;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int divs[8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
  reg [7:0] v;
  watchdog_interval_timer uut (.ref_clk, .rstn, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .standbyReq, .nmiPin, .standbyActive, .standbyRefused, .intervalInterrupt,
    .overflow_output_n, .internalReset, .internalResetPowerOn, .internalResetManual,
    .portInitReq);
  sys_reset_circuit far (.ref_clk, .overflow_output_n, .resetCount);
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish;
    if (num_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  task automatic wr(input [1:0] a, input [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input [1:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic er(input [1:0] a, input [7:0] e, input string n);
    rd(a);
    `CHK(n, e, v)
  endtask
  task automatic req;
    @(posedge ref_clk);
    standbyReq <= 1'b1;
    @(posedge ref_clk);
    standbyReq <= 1'b0;
    #1;
  endtask
  task automatic wdRun(input [15:0] rst);
    wr(2'h2, rst);
    wr(2'h0, 16'ha560);
    wr(2'h0, 16'h5af0);
    repeat (100) if (overflow_output_n) @(posedge ref_clk);
    `CHK("ovfOut", 1'b0, overflow_output_n)
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    `CHK("portInitRst", 1'b1, portInitReq)
    rstn <= 1'b1;
    er(2'h0, 8'h18, "ctrlRst");
    er(2'h1, 8'h00, "countRst");
    er(2'h3, 8'h1f, "rstCtlRst");
    wr(2'h0, 16'ha520);
    repeat (600) if (!intervalInterrupt) @(posedge ref_clk);
    `CHK("iti", 1'b1, intervalInterrupt)
    er(2'h0, 8'hb8, "ctrlOvf");
    wr(2'h0, 16'ha520);
    `CHK("itiClear", 1'b0, intervalInterrupt)
    repeat (400) @(posedge ref_clk);
    `CHK("itiEarly", 1'b0, intervalInterrupt)
    repeat (200) if (!intervalInterrupt) @(posedge ref_clk);
    `CHK("itiAgain", 1'b1, intervalInterrupt)
    wr(2'h0, 16'ha500);
    er(2'h1, 8'h00, "countHeld");
    er(2'h0, 8'h98, "ctrlStop");
    wr(2'h0, 16'ha500);
    for (int i = 0; i < 8; i++) begin
      wr(2'h0, {8'ha5, 5'h00, i[2:0]});
      wr(2'h0, {8'ha5, 5'h04, i[2:0]});
      repeat (4 * divs[i]) @(posedge ref_clk);
      rd(2'h1);
      `CHK("divCount", 1'b1, v >= 8'h03 && v <= 8'h05)
    end
    wr(2'h0, 16'ha500);
    wdRun(16'h5a60);
    `CHK("rstManual", 1'b1, internalResetManual)
    `CHK("portKeep", 1'b0, portInitReq)
    er(2'h3, 8'hff, "wdFlagSet");
    er(2'h0, 8'h18, "ctrlAfterWd");
    wr(2'h2, 16'ha500);
    er(2'h3, 8'h7f, "wdFlagClear");
    repeat (600) @(posedge ref_clk);
    `CHK("rstDone", 1'b0, internalReset)
    `CHK("farResets", 8'h01, resetCount)
    wdRun(16'h5a00);
    `CHK("noChipRst", 1'b0, internalReset)
    er(2'h1, 8'h00, "countAfterWd");
    er(2'h0, 8'h18, "ctrlNoRst");
    repeat (200) @(posedge ref_clk);
    wr(2'h0, 16'ha560);
    for (int i = 0; i < 4; i++) begin
      repeat (300) @(posedge ref_clk);
      wr(2'h0, 16'h5a00);
    end
    `CHK("reloadHolds", 8'h02, resetCount)
    wr(2'h0, 16'ha500);
    wdRun(16'h5a40);
    `CHK("rstPowerOn", 1'b1, internalResetPowerOn)
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("portInitPin", 1'b1, portInitReq)
    rstn <= 1'b1;
    er(2'h3, 8'h1f, "wdFlagPin");
    `CHK("ovfPin", 1'b1, overflow_output_n)
    wr(2'h0, 16'ha520);
    req;
    `CHK("refused", 1'b1, standbyRefused)
    `CHK("notStandby", 1'b0, standbyActive)
    wr(2'h0, 16'ha500);
    req;
    `CHK("standby", 1'b1, standbyActive)
    @(posedge ref_clk);
    nmiPin <= 1'b1;
    repeat (300) @(posedge ref_clk);
    `CHK("wakeCounting", 1'b1, standbyActive)
    repeat (400) if (standbyActive) @(posedge ref_clk);
    `CHK("woken", 1'b0, standbyActive)
    nmiPin <= 1'b0;
    tally_and_finish;
  end
endmodule
